/* File: logic/can_cfg_pkg.sv */
// constants for the can node configuration object bank
package can_cfg_pkg;
    // ----------------------------------------
    // object indices and subindices
    // ----------------------------------------
    localparam logic [15:0] IDX_PROGRESS  = 16'h1f57;
    localparam logic [15:0] IDX_STARTUP   = 16'h1f80;
    localparam logic [15:0] IDX_RATE      = 16'h2005;
    localparam logic [15:0] IDX_SWITCH    = 16'h2006;
    localparam logic [15:0] IDX_NODE_ADDR = 16'h2009;
    localparam logic [7:0]  SUB_COUNT     = 8'h00;
    localparam logic [7:0]  SUB_FIRST     = 8'h01;
    localparam logic [7:0]  SUB_SECOND    = 8'h02;
    localparam logic [7:0]  ARRAY_ENTRIES = 8'h02;
    // ----------------------------------------
    // reset values and fields
    // ----------------------------------------
    localparam logic [31:0] STARTUP_RST   = 32'h0000_0000;
    localparam int          STARTUP_OP_BIT = 3;
    localparam logic [7:0]  RATE_RST      = 8'h88;
    localparam logic [7:0]  NODE_ADDR_RST = 8'h7f;
    localparam logic [7:0]  OFFSET_RST    = 8'h00;
    localparam logic [7:0]  OFFSET_MAX    = 8'h70;
    // ----------------------------------------
    // decoded bit rates in kbd
    // ----------------------------------------
    localparam logic [10:0] KBD_10   = 11'h00a;
    localparam logic [10:0] KBD_20   = 11'h014;
    localparam logic [10:0] KBD_50   = 11'h032;
    localparam logic [10:0] KBD_125  = 11'h07d;
    localparam logic [10:0] KBD_250  = 11'h0fa;
    localparam logic [10:0] KBD_500  = 11'h1f4;
    localparam logic [10:0] KBD_1000 = 11'h3e8;
    // ----------------------------------------
    // network states before and after initialization
    // ----------------------------------------
    typedef enum logic [1:0] {
        NMT_INIT    = 2'h0,
        NMT_PREOP   = 2'h1,
        NMT_OPER    = 2'h3
    } nmt_state_e;
    // rate code to kbd, unknown codes fall to full speed
    function automatic logic [10:0] decode_rate(input logic [7:0] code);
        unique case (code)
            8'h81:   decode_rate = KBD_10;
            8'h82:   decode_rate = KBD_20;
            8'h83:   decode_rate = KBD_50;
            8'h84:   decode_rate = KBD_125;
            8'h85:   decode_rate = KBD_250;
            8'h86:   decode_rate = KBD_500;
            default: decode_rate = KBD_1000;
        endcase
    endfunction
endpackage

/* File: logic/node_addr_calc.sv */
// node address derivation from rotary switch and offset
module node_addr_calc
    import can_cfg_pkg::*;
(
    input  wire logic [7:0] switch_i,
    input  wire logic       offset_en_i,
    input  wire logic [7:0] node_address_offset_i,
    output logic      [7:0] addr_o
);
    // offsets above the legal range are the master's fault; sum wraps to 8 bits
    always_comb begin
        if (offset_en_i) begin
            addr_o = 8'(switch_i + node_address_offset_i);
        end else begin
            addr_o = switch_i;
        end
    end
endmodule // node_addr_calc

/* File: logic/can_node_config_objects.sv */
// dictionary object bank for the can node configuration
module can_node_config_objects
    import can_cfg_pkg::*;
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    // dictionary access
    input  wire logic        obj_wr_i,
    input  wire logic        obj_rd_i,
    input  wire logic [15:0] obj_index_i,
    input  wire logic [7:0]  obj_sub_i,
    input  wire logic [31:0] obj_wdata_i,
    output logic      [31:0] obj_rdata_o,
    output logic             obj_ack_o,
    output logic             obj_err_o,
    // programming progress from the loader
    input  wire logic        prog_fw_we_i,
    input  wire logic        prog_user_we_i,
    input  wire logic [31:0] prog_status_i,
    // rotary switch and initialization
    input  wire logic [7:0]  switch_i,
    input  wire logic        init_done_i,
    // applied settings
    output nmt_state_e       nmt_state_o,
    output logic      [10:0] bit_rate_kbd_o,
    output logic      [7:0]  node_addr_o
);
    // ----------------------------------------
    // stored objects
    // ----------------------------------------
    logic [31:0] progress_reg [2];
    logic [31:0] progress_next [2];
    logic [31:0] startup_reg, startup_next;
    logic [7:0]  rate_reg, rate_next;
    logic        offset_en_reg, offset_en_next;
    logic [7:0]  offset_reg, offset_next;
    logic [7:0]  node_obj_reg, node_obj_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        ack_reg, ack_next;
    logic        err_reg, err_next;
    nmt_state_e  nmt_reg, nmt_next;
    logic [10:0] kbd_reg, kbd_next;
    logic [7:0]  addr_reg, addr_next;
    logic        applied_reg, applied_next;
    logic [7:0]  derived_addr;

    // byte objects sit in the low byte of the read word
    function automatic logic [31:0] byte_word(input logic [7:0] value);
        byte_word = {24'h0, value};
    endfunction

    node_addr_calc u_calc (
        .switch_i              (switch_i),
        .offset_en_i           (offset_en_reg),
        .node_address_offset_i (offset_reg),
        .addr_o                (derived_addr)
    );

    // ----------------------------------------
    // object access
    // ----------------------------------------
    always_comb begin
        progress_next = progress_reg;
        startup_next  = startup_reg;
        rate_next     = rate_reg;
        offset_en_next = offset_en_reg;
        offset_next   = offset_reg;
        node_obj_next = node_obj_reg;
        rdata_next    = rdata_reg;
        ack_next      = 1'b0;
        err_next      = 1'b0;
        // progress is written by the loader only, never by the master
        if (prog_fw_we_i) begin
            progress_next[0] = prog_status_i;
        end
        if (prog_user_we_i) begin
            progress_next[1] = prog_status_i;
        end
        if (obj_wr_i || obj_rd_i) begin
            ack_next = 1'b1;
            unique case (obj_index_i)
                IDX_PROGRESS: begin
                    if (obj_wr_i) begin
                        err_next = 1'b1;
                    end else if (obj_sub_i == SUB_COUNT) begin
                        rdata_next = byte_word(ARRAY_ENTRIES);
                    end else if (obj_sub_i == SUB_FIRST) begin
                        rdata_next = progress_reg[0];
                    end else if (obj_sub_i == SUB_SECOND) begin
                        rdata_next = progress_reg[1];
                    end else begin
                        err_next = 1'b1;
                    end
                end
                IDX_STARTUP: begin
                    if (obj_wr_i) begin
                        startup_next = obj_wdata_i;
                    end else begin
                        rdata_next = startup_reg;
                    end
                end
                IDX_RATE: begin
                    if (obj_wr_i) begin
                        rate_next = obj_wdata_i[7:0];
                    end else begin
                        rdata_next = byte_word(rate_reg);
                    end
                end
                IDX_SWITCH: begin
                    if (obj_sub_i == SUB_COUNT) begin
                        err_next = obj_wr_i;
                        rdata_next = obj_wr_i ? rdata_reg : byte_word(ARRAY_ENTRIES);
                    end else if (obj_sub_i == SUB_FIRST) begin
                        if (obj_wr_i) begin
                            // only 0 or 1 is legal for the enable
                            if (obj_wdata_i[7:1] == 7'h0) begin
                                offset_en_next = obj_wdata_i[0];
                            end else begin
                                err_next = 1'b1;
                            end
                        end else begin
                            rdata_next = {31'h0, offset_en_reg};
                        end
                    end else if (obj_sub_i == SUB_SECOND) begin
                        if (obj_wr_i) begin
                            // stored as written; the master keeps it in range
                            offset_next = obj_wdata_i[7:0];
                        end else begin
                            rdata_next = byte_word(offset_reg);
                        end
                    end else begin
                        err_next = 1'b1;
                    end
                end
                IDX_NODE_ADDR: begin
                    if (obj_wr_i) begin
                        node_obj_next = obj_wdata_i[7:0];
                    end else begin
                        rdata_next = byte_word(node_obj_reg);
                    end
                end
                default: begin
                    err_next = 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------
    // apply settings once at initialization
    // ----------------------------------------
    always_comb begin
        nmt_next     = nmt_reg;
        kbd_next     = kbd_reg;
        addr_next    = addr_reg;
        applied_next = applied_reg;
        // later writes are never applied; the next reset restores the reset values first, so the bus never changes mid-traffic
        if (init_done_i && !applied_reg) begin
            applied_next = 1'b1;
            kbd_next     = decode_rate(rate_reg);
            addr_next    = derived_addr;
            if (startup_reg[STARTUP_OP_BIT]) begin
                nmt_next = NMT_OPER;
            end else begin
                nmt_next = NMT_PREOP;
            end
        end
    end

    // ----------------------------------------
    // object registers
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            progress_reg[0] <= 32'h0000_0000;
            progress_reg[1] <= 32'h0000_0000;
            startup_reg   <= STARTUP_RST;
            rate_reg      <= RATE_RST;
            offset_en_reg <= 1'b0;
            offset_reg    <= OFFSET_RST;
            node_obj_reg  <= NODE_ADDR_RST;
            rdata_reg     <= 32'h0000_0000;
            ack_reg       <= 1'b0;
            err_reg       <= 1'b0;
        end else begin
            progress_reg  <= progress_next;
            startup_reg   <= startup_next;
            rate_reg      <= rate_next;
            offset_en_reg <= offset_en_next;
            offset_reg    <= offset_next;
            node_obj_reg  <= node_obj_next;
            rdata_reg     <= rdata_next;
            ack_reg       <= ack_next;
            err_reg       <= err_next;
        end
    end

    // ----------------------------------------
    // applied setting registers
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            nmt_reg       <= NMT_INIT;
            kbd_reg       <= KBD_1000;
            addr_reg      <= NODE_ADDR_RST;
            applied_reg   <= 1'b0;
        end else begin
            nmt_reg       <= nmt_next;
            kbd_reg       <= kbd_next;
            addr_reg      <= addr_next;
            applied_reg   <= applied_next;
        end
    end

    assign obj_rdata_o    = rdata_reg;
    assign obj_ack_o      = ack_reg;
    assign obj_err_o      = err_reg;
    assign nmt_state_o    = nmt_reg;
    assign bit_rate_kbd_o = kbd_reg;
    assign node_addr_o    = addr_reg;
endmodule // can_node_config_objects

/* File: dv/switch_model.sv */
// rotary switch model feeding the node address input
module switch_model (
    // clock
    input  wire logic       clock_i,
    // position set by the bench
    input  wire logic [7:0] position_i,
    // synchronous reading
    output logic      [7:0] switch_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // registered so a turn never lands mid-cycle at the block
    always_ff @(posedge clock_i) begin
        switch_o <= position_i;
    end
endmodule // switch_model

/* File: dv/can_cfg_asserts.sv */
// assertion checker for the can node configuration objects
module can_cfg_checker
    import can_cfg_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        nrst_i,
    input wire logic        obj_wr_i,
    input wire logic [15:0] obj_index_i,
    input wire logic [7:0]  obj_sub_i,
    input wire logic [31:0] obj_wdata_i,
    input wire logic        obj_ack_o,
    input wire logic        obj_err_o,
    input wire logic [7:0]  switch_i,
    input wire logic        init_done_i,
    input wire nmt_state_e  nmt_state_o,
    input wire logic [10:0] bit_rate_kbd_o,
    input wire logic [7:0]  node_addr_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // shadow of the stored settings; refused enable values leave it alone
    logic       en_reg, op_reg;
    logic [7:0] off_reg, rate_reg;
    wire logic       latch = nmt_state_o == NMT_INIT && init_done_i;
    wire logic [7:0] sum   = switch_i + off_reg;
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            en_reg   <= 1'b0;
            op_reg   <= 1'b0;
            off_reg  <= OFFSET_RST;
            rate_reg <= RATE_RST;
        end else if (obj_wr_i) begin
            if (obj_index_i == IDX_STARTUP) op_reg <= obj_wdata_i[STARTUP_OP_BIT];
            if (obj_index_i == IDX_RATE) rate_reg <= obj_wdata_i[7:0];
            if (obj_index_i == IDX_SWITCH && obj_sub_i == SUB_FIRST && obj_wdata_i[7:1] == 7'h0) en_reg <= obj_wdata_i[0];
            if (obj_index_i == IDX_SWITCH && obj_sub_i == SUB_SECOND) off_reg <= obj_wdata_i[7:0];
        end
    end
    a_ro_refused: assert property (obj_wr_i && obj_index_i == IDX_PROGRESS |=> obj_ack_o && obj_err_o)
        else $error("progress write not refused");
    a_init_wait: assert property (nmt_state_o == NMT_INIT && !init_done_i |=> nmt_state_o == NMT_INIT)
        else $error("left init early");
    a_start_preop: assert property (latch && !op_reg |=> nmt_state_o == NMT_PREOP)
        else $error("not pre-operational");
    a_start_oper: assert property (latch && op_reg |=> nmt_state_o == NMT_OPER)
        else $error("not operational");
    a_rate_slowest: assert property (latch && rate_reg == 8'h81 |=> bit_rate_kbd_o == KBD_10)
        else $error("slowest rate wrong");
    a_rate_fallback: assert property (latch && !(rate_reg inside {[8'h81:8'h86]}) |=> bit_rate_kbd_o == KBD_1000)
        else $error("fallback rate wrong");
    a_addr_plain: assert property (latch && !en_reg |=> node_addr_o == $past(switch_i))
        else $error("plain address wrong");
    a_addr_offset: assert property (latch && en_reg |=> node_addr_o == $past(sum))
        else $error("offset address wrong");
    a_applied_hold: assert property (nmt_state_o != NMT_INIT |=> $stable(bit_rate_kbd_o) && $stable(node_addr_o))
        else $error("applied setting moved");
    c_offset_used: cover property (latch && en_reg);
    c_oper_start: cover property (latch && op_reg);
    c_ro_write: cover property (obj_wr_i && obj_index_i == IDX_PROGRESS);
endmodule // can_cfg_checker
bind can_node_config_objects can_cfg_checker can_cfg_checker_i (.clock_i(clock_i), .nrst_i(nrst_i),
    .obj_wr_i(obj_wr_i), .obj_index_i(obj_index_i), .obj_sub_i(obj_sub_i), .obj_wdata_i(obj_wdata_i),
    .obj_ack_o(obj_ack_o), .obj_err_o(obj_err_o), .switch_i(switch_i), .init_done_i(init_done_i),
    .nmt_state_o(nmt_state_o), .bit_rate_kbd_o(bit_rate_kbd_o), .node_addr_o(node_addr_o));

/* File: dv/tb.sv */
// self-checking testbench for the can node configuration objects
module tb
    import can_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i = 1'b0, nrst_i = 1'b0, init_done_i = 1'b0;
    logic        obj_wr_i = 1'b0, obj_rd_i = 1'b0, prog_fw_we_i = 1'b0, prog_user_we_i = 1'b0;
    logic [15:0] obj_index_i = 16'h0;
    logic [7:0]  obj_sub_i = 8'h0, position = 8'h0, switch_i, node_addr_o;
    logic [31:0] obj_wdata_i = 32'h0, prog_status_i = 32'h0, obj_rdata_o;
    logic        obj_ack_o, obj_err_o;
    nmt_state_e  nmt_state_o;
    logic [10:0] bit_rate_kbd_o;
    int          fails = 0, n_checks = 0;
    localparam logic [7:0]  CODES [10] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h88, 8'h87, 8'h00, 8'hff};
    localparam logic [10:0] RATES [10] = '{KBD_10, KBD_20, KBD_50, KBD_125, KBD_250, KBD_500, KBD_1000,
                                           KBD_1000, KBD_1000, KBD_1000};
    always #10 clock_i = ~clock_i;
    switch_model switch_model_i (.clock_i(clock_i), .position_i(position), .switch_o(switch_i));
    can_node_config_objects can_node_config_objects_i (.clock_i(clock_i), .nrst_i(nrst_i), .obj_wr_i(obj_wr_i),
        .obj_rd_i(obj_rd_i), .obj_index_i(obj_index_i), .obj_sub_i(obj_sub_i), .obj_wdata_i(obj_wdata_i),
        .obj_rdata_o(obj_rdata_o), .obj_ack_o(obj_ack_o), .obj_err_o(obj_err_o), .prog_fw_we_i(prog_fw_we_i),
        .prog_user_we_i(prog_user_we_i), .prog_status_i(prog_status_i), .switch_i(switch_i),
        .init_done_i(init_done_i), .nmt_state_o(nmt_state_o), .bit_rate_kbd_o(bit_rate_kbd_o),
        .node_addr_o(node_addr_o));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic restart();
        @(posedge clock_i);
        nrst_i <= 1'b0;
        repeat (5) @(posedge clock_i);
        nrst_i <= 1'b1;
    endtask
    // one access; the answer is read 1 ns after the taking edge
    task automatic acc(input logic w, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] wd,
                       output logic [31:0] rd, output logic [1:0] st);
        @(posedge clock_i);
        obj_wr_i <= w;
        obj_rd_i <= !w;
        obj_index_i <= ix;
        obj_sub_i <= sb;
        obj_wdata_i <= wd;
        @(posedge clock_i);
        obj_wr_i <= 1'b0;
        obj_rd_i <= 1'b0;
        #1;
        rd = obj_rdata_o;
        st = {obj_err_o, obj_ack_o};
    endtask
    task automatic rd_chk(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] exp, input string nm);
        logic [31:0] rd;
        logic [1:0]  st;
        acc(1'b0, ix, sb, 32'h0, rd, st);
        chk(nm, rd, exp);
        chk({nm, " status"}, {30'h0, st}, 32'h1);
    endtask
    task automatic apply();
        @(posedge clock_i);
        init_done_i <= 1'b1;
        @(posedge clock_i);
        init_done_i <= 1'b0;
        #1;
    endtask
    task automatic t_presets();
        logic [31:0] rd;
        logic [1:0]  st;
        restart();
        rd_chk(IDX_STARTUP, SUB_COUNT, 32'h0, "startup");
        rd_chk(IDX_RATE, SUB_COUNT, 32'h88, "rate");
        rd_chk(IDX_SWITCH, SUB_FIRST, 32'h0, "enable");
        rd_chk(IDX_SWITCH, SUB_SECOND, 32'h0, "offset");
        rd_chk(IDX_NODE_ADDR, SUB_COUNT, 32'h7f, "node id");
        chk("outputs", {nmt_state_o, bit_rate_kbd_o, node_addr_o}, {2'h0, KBD_1000, 8'h7f});
        acc(1'b1, IDX_NODE_ADDR, SUB_COUNT, 32'h22, rd, st);
        rd_chk(IDX_NODE_ADDR, SUB_COUNT, 32'h22, "node id rw");
        $display("test presets done");
    endtask
    task automatic t_progress();
        logic [31:0] rd;
        logic [1:0]  st;
        @(posedge clock_i);
        prog_fw_we_i <= 1'b1;
        prog_user_we_i <= 1'b1;
        prog_status_i <= 32'h1234_5678;
        @(posedge clock_i);
        prog_fw_we_i <= 1'b0;
        prog_status_i <= 32'h0000_00a5;
        @(posedge clock_i);
        prog_user_we_i <= 1'b0;
        rd_chk(IDX_PROGRESS, SUB_COUNT, 32'h2, "entries");
        rd_chk(IDX_PROGRESS, SUB_FIRST, 32'h1234_5678, "firmware");
        rd_chk(IDX_PROGRESS, SUB_SECOND, 32'ha5, "user");
        acc(1'b1, IDX_PROGRESS, SUB_FIRST, 32'h0, rd, st);
        chk("ro write", {30'h0, st}, 32'h3);
        rd_chk(IDX_PROGRESS, SUB_FIRST, 32'h1234_5678, "firmware kept");
        acc(1'b1, IDX_SWITCH, SUB_FIRST, 32'h2, rd, st);
        chk("enable 2", {30'h0, st}, 32'h3);
        rd_chk(IDX_SWITCH, SUB_COUNT, 32'h2, "switch entries");
        acc(1'b0, IDX_PROGRESS, 8'h03, 32'h0, rd, st);
        chk("bad sub", {30'h0, st}, 32'h3);
        $display("test progress done");
    endtask
    task automatic t_apply();
        logic [31:0] rd;
        logic [1:0]  st;
        logic [7:0]  off, ea;
        for (int i = 0; i < 10; i++) begin
            restart();
            position <= 8'h05 + 8'(i);
            off = 8'd112 - 8'(i * 12);
            ea = i[0] ? 8'h05 + 8'(i) + off : 8'h05 + 8'(i);
            acc(1'b1, IDX_RATE, SUB_COUNT, {24'h0, CODES[i]}, rd, st);
            acc(1'b1, IDX_SWITCH, SUB_FIRST, {31'h0, i[0]}, rd, st);
            acc(1'b1, IDX_SWITCH, SUB_SECOND, {24'h0, off}, rd, st);
            acc(1'b1, IDX_STARTUP, SUB_COUNT, i[1] ? 32'h8 : 32'h0, rd, st);
            apply();
            chk("kbd", {21'h0, bit_rate_kbd_o}, {21'h0, RATES[i]});
            chk("state", {30'h0, nmt_state_o}, i[1] ? 32'h3 : 32'h1);
            chk("addr", {24'h0, node_addr_o}, {24'h0, ea});
            acc(1'b1, IDX_RATE, SUB_COUNT, 32'h81, rd, st);
            acc(1'b1, IDX_SWITCH, SUB_FIRST, {31'h0, ~i[0]}, rd, st);
            apply();
            chk("kept", {13'h0, bit_rate_kbd_o, node_addr_o}, {13'h0, RATES[i], ea});
        end
        $display("test apply done");
    endtask
    initial begin
        repeat (60000) @(posedge clock_i);
        fails++;
        wrap_up();
    end
    initial begin
        t_presets();
        t_progress();
        t_apply();
        wrap_up();
    end
endmodule // tb
